// >>> ea_fp_map.svh
// effective address and extended real format constants
// Operation
// RULE_01 - extended real occupies three long words; 80 used, 16 reserved
// RULE_02 - extended real splits into sign, 15-bit exponent, 64-bit mantissa
// RULE_03 - single and double operands follow the standard bit layouts exactly
// RULE_04 - address register indirect: plain, postinc, predec, displacement, index
// RULE_05 - 8 and 16 bit displacements are sign-extended before adding to base
// RULE_06 - index from any register, word or long, scaled by 1, 2, 4 or 8
// RULE_07 - base displacement accepted as 16 or 32 bit two's complement
// RULE_08 - optional outer displacement added only after the indirect fetch
// RULE_09 - memory indirect fetches intermediate long word; index pre or post
// RULE_10 - program counter relative forms mirror the address register forms
// RULE_11 - immediate operands come from the stream as 8, 16 or 32 bits
// RULE_12 - every data format works with every fitting addressing mode; code sizes only byte, word and long, not double or extended
// RULE_13 - postincrement adds size after access; predecrement subtracts before
// RULE_14 - absolute short sign-extends 16 bits; absolute long uses 32 bits
`ifndef EA_FP_MAP_SVH
`define EA_FP_MAP_SVH
`define EXT_MEM_BITS     96
`define EXT_SIGN_POS     95
`define EXT_EXP_HI       94
`define EXT_EXP_LO       80
`define EXT_RSV_HI       79
`define EXT_RSV_LO       64
`define EXT_MANT_HI      63
`define SGL_EXP_BITS     8
`define SGL_MANT_BITS    23
`define DBL_EXP_BITS     11
`define DBL_MANT_BITS    52
`define EXT_EXP_BITS     15
`define EXT_BIAS         15'h3fff
`define SGL_BIAS         15'h007f
`define DBL_BIAS         15'h03ff
`endif

// >>> ea_fp_pkg.sv
// types for effective address generation and real formats
package ea_fp_pkg;
	typedef enum logic [3:0] {
		M_IND     = 4'b0000,
		M_POSTINC = 4'b0001,
		M_PREDEC  = 4'b0010,
		M_DISP16  = 4'b0011,
		M_IDX8    = 4'b0100,
		M_IDXBD   = 4'b0101,
		M_MEMPOST = 4'b0110,
		M_MEMPRE  = 4'b0111,
		M_ABSW    = 4'b1000,
		M_ABSL    = 4'b1001,
		M_IMM     = 4'b1010
	} ea_mode_e;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} op_size_e;
	typedef enum logic [1:0] {
		RF_SINGLE   = 2'b00,
		RF_DOUBLE   = 2'b01,
		RF_EXTENDED = 2'b10
	} real_fmt_e;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_DONE  = 2'b10
	} ea_state_e;
	typedef struct packed {
		ea_state_e   st;
		logic        post_idx;
		logic [31:0] od;
		logic [31:0] idx;
		logic [31:0] addr;
		logic [31:0] base_wb;
		logic        wb_en;
		logic        done;
		logic [95:0] ext;
	} ea_state_s;
endpackage

// >>> ea_fp_unit.sv
// effective address generator and extended real packer
`include "ea_fp_map.svh"
module ea_fp_unit import ea_fp_pkg::*; (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// request from decoder
	input  wire logic        ea_start,
	input  wire ea_mode_e    ea_mode,
	input  wire logic        pc_relative,
	input  wire op_size_e    op_size,
	input  wire logic [31:0] address_register_base,
	input  wire logic [31:0] pc_value,
	input  wire logic [31:0] index_register_operand,
	input  wire logic        index_long,
	input  wire logic [1:0]  index_scale,
	input  wire logic [7:0]  short_byte_displacement,
	input  wire logic [15:0] short_word_displacement,
	input  wire logic [31:0] base_displacement,
	input  wire logic        bd_long,
	input  wire logic [31:0] outer_displacement,
	input  wire logic        od_present,
	input  wire logic        od_long,
	input  wire logic [31:0] ext_word,
	input  wire logic [31:0] data_register_operand,
	// indirect fetch port
	output logic             fetch_req,
	output logic [31:0]      fetch_addr,
	input  wire logic        fetch_ack,
	input  wire logic [31:0] fetch_data,
	// result
	output logic             ea_done,
	output logic [31:0]      ea_addr,
	output logic [31:0]      imm_value,
	output logic             base_wb_en,
	output logic [31:0]      base_wb_value,
	// real format conversion
	input  wire logic        fp_load,
	input  wire real_fmt_e   fp_fmt,
	input  wire logic [63:0] fp_in,
	output logic [95:0]      ext_image,
	output logic             ext_sign,
	output logic [14:0]      ext_exponent,
	output logic [63:0]      ext_mantissa
);

	ea_state_s s_q, s_d;

	function automatic logic [31:0] sx16(input logic [15:0] v);
		sx16 = {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] size_bytes(input op_size_e z);
		case (z)
			SZ_BYTE: size_bytes = 32'h0000_0001;
			SZ_WORD: size_bytes = 32'h0000_0002;
			default: size_bytes = 32'h0000_0004;
		endcase
	endfunction

	logic [31:0] base, idx_raw, idx_sc, bd_ext, od_ext, sz;
	logic [31:0] inner;
	logic [14:0] e_in;
	logic [63:0] m_in;
	logic        s_in;
	logic        zero_exp;

	always_comb begin
		base    = pc_relative ? pc_value : address_register_base; // [RULE_10]
		idx_raw = index_long ? index_register_operand
			: sx16(index_register_operand[15:0]); // [RULE_06]
		idx_sc  = idx_raw << index_scale; // [RULE_06]
		bd_ext  = bd_long ? base_displacement
			: sx16(base_displacement[15:0]); // [RULE_07]
		od_ext  = !od_present ? 32'h0000_0000
			: (od_long ? outer_displacement
			: sx16(outer_displacement[15:0])); // [RULE_08]
		sz      = size_bytes(op_size); // [RULE_12]
		inner   = base + bd_ext;
	end

	// real unpack: single/double widened to extended at standard bit places
	always_comb begin
		s_in     = 1'b0;
		e_in     = 15'h0000;
		m_in     = 64'h0000_0000_0000_0000;
		zero_exp = 1'b0;
		case (fp_fmt)
			RF_SINGLE: begin // [RULE_03]
				s_in     = fp_in[31];
				zero_exp = (fp_in[30:23] == 8'h00);
				e_in     = (fp_in[30:23] == 8'hff) ? 15'h7fff
					: zero_exp ? 15'h0000
					: 15'({7'h00, fp_in[30:23]}) - `SGL_BIAS + `EXT_BIAS;
				m_in     = {~zero_exp, fp_in[22:0], 40'h00_0000_0000};
			end
			RF_DOUBLE: begin // [RULE_03]
				s_in     = fp_in[63];
				zero_exp = (fp_in[62:52] == 11'h000);
				e_in     = (fp_in[62:52] == 11'h7ff) ? 15'h7fff
					: zero_exp ? 15'h0000
					: 15'({4'h0, fp_in[62:52]}) - `DBL_BIAS + `EXT_BIAS;
				m_in     = {~zero_exp, fp_in[51:0], 11'h000};
			end
			default: begin // [RULE_02]
				s_in = s_q.ext[`EXT_SIGN_POS];
				e_in = s_q.ext[`EXT_EXP_HI:`EXT_EXP_LO];
				m_in = fp_in;
			end
		endcase
	end

	always_comb begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		s_d.wb_en   = 1'b0;
		if (fp_load) begin
			// reserved 16 bits stay zero for long-word alignment
			s_d.ext = {s_in, e_in, 16'h0000, m_in}; // [RULE_01] [RULE_02]
		end
		case (s_q.st)
			ST_IDLE: begin
				if (ea_start) begin
					s_d.done = 1'b1;
					s_d.idx  = idx_sc;
					s_d.od   = od_ext;
					case (ea_mode)
						M_IND: s_d.addr = base; // [RULE_04]
						M_POSTINC: begin
							s_d.addr    = base; // [RULE_13]
							s_d.base_wb = base + sz;
							s_d.wb_en   = 1'b1;
						end
						M_PREDEC: begin
							s_d.addr    = base - sz; // [RULE_13]
							s_d.base_wb = base - sz;
							s_d.wb_en   = 1'b1;
						end
						M_DISP16: s_d.addr = base
							+ sx16(short_word_displacement); // [RULE_05]
						M_IDX8: s_d.addr = base
							+ {{24{short_byte_displacement[7]}},
							short_byte_displacement} + idx_sc; // [RULE_05]
						M_IDXBD: s_d.addr = inner + idx_sc; // [RULE_07]
						M_MEMPOST, M_MEMPRE: begin
							s_d.done     = 1'b0;
							s_d.post_idx = (ea_mode == M_MEMPOST);
							s_d.addr     = (ea_mode == M_MEMPRE)
								? inner + idx_sc : inner; // [RULE_09]
							s_d.st       = ST_FETCH;
						end
						M_ABSW: s_d.addr = sx16(ext_word[15:0]); // [RULE_14]
						M_ABSL: s_d.addr = ext_word; // [RULE_14]
						default: s_d.addr = 32'h0000_0000;
					endcase
				end
			end
			ST_FETCH: begin
				if (fetch_ack) begin
					// outer displacement only after the fetch returns
					s_d.addr = fetch_data + s_q.od
						+ (s_q.post_idx ? s_q.idx
						: 32'h0000_0000); // [RULE_08] [RULE_09]
					s_d.done = 1'b1;
					s_d.st   = ST_DONE;
				end
			end
			ST_DONE: s_d.st = ST_IDLE;
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [31:0] imm_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			imm_q <= 32'h0000_0000;
		end else if (ea_start && s_q.st == ST_IDLE && ea_mode == M_IMM) begin
			case (op_size) // [RULE_11]
				SZ_BYTE: imm_q <= {24'h00_0000, ext_word[7:0]};
				SZ_WORD: imm_q <= {16'h0000, ext_word[15:0]};
				default: imm_q <= ext_word;
			endcase
		end
	end

	assign fetch_req     = (s_q.st == ST_FETCH);
	assign fetch_addr    = s_q.addr;
	assign ea_done       = s_q.done;
	assign ea_addr       = s_q.addr;
	assign imm_value     = imm_q;
	assign base_wb_en    = s_q.wb_en;
	assign base_wb_value = s_q.base_wb;
	assign ext_image     = s_q.ext;
	assign ext_sign      = s_q.ext[`EXT_SIGN_POS];
	assign ext_exponent  = s_q.ext[`EXT_EXP_HI:`EXT_EXP_LO];
	assign ext_mantissa  = s_q.ext[`EXT_MANT_HI:0];

	////////////////////////////////////////////////////////////////////////
	// checks
	postinc_size_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start && ea_mode == M_POSTINC)
		|=> (base_wb_en && base_wb_value == ea_addr + $past(sz)))
		else $error("postincrement writeback wrong"); // [RULE_13]
	predec_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start && ea_mode == M_PREDEC)
		|=> (ea_addr == base_wb_value && ea_addr == $past(base) - $past(sz)))
		else $error("predecrement address wrong"); // [RULE_13]
	disp16_sext_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start && ea_mode == M_DISP16)
		|=> ea_addr == $past(base) + sx16($past(short_word_displacement)))
		else $error("word displacement not sign-extended"); // [RULE_05]
	abs_short_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start && ea_mode == M_ABSW)
		|=> ea_addr[31:16] == {16{ea_addr[15]}})
		else $error("absolute short not sign-extended"); // [RULE_14]
	fetch_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fetch_req && fetch_ack) |=> (ea_done && !fetch_req))
		else $error("indirect fetch did not complete"); // [RULE_09]
	indirect_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start
		&& (ea_mode == M_MEMPOST || ea_mode == M_MEMPRE))
		|=> (fetch_req && !ea_done))
		else $error("indirect mode skipped fetch"); // [RULE_08]
	ext_reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext_image[`EXT_RSV_HI:`EXT_RSV_LO] == 16'h0000)
		else $error("reserved bits of extended image set"); // [RULE_01]
	single_sign_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fp_load && fp_fmt == RF_SINGLE) |=> ext_sign == $past(fp_in[31]))
		else $error("single sign misplaced"); // [RULE_03]
	imm_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s_q.st == ST_IDLE && ea_start && ea_mode == M_IMM
		&& op_size == SZ_BYTE) |=> imm_value[31:8] == 24'h00_0000)
		else $error("byte immediate has upper bits"); // [RULE_11]

endmodule // ea_fp_unit

// >>> tb_effective_address_and_fp_format.sv
// self-checking bench for address generation and extended real packing
module tb_effective_address_and_fp_format import ea_fp_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys, rst_n, ea_start, pc_relative, index_long;
	logic        bd_long, od_present, od_long, fetch_ack, fp_load;
	logic        fetch_req, ea_done, base_wb_en, ext_sign;
	ea_mode_e    ea_mode;
	op_size_e    op_size;
	real_fmt_e   fp_fmt;
	logic [1:0]  index_scale;
	logic [7:0]  short_byte_displacement;
	logic [15:0] short_word_displacement;
	logic [14:0] ext_exponent;
	logic [31:0] address_register_base, pc_value, index_register_operand;
	logic [31:0] base_displacement, outer_displacement, ext_word;
	logic [31:0] data_register_operand, fetch_addr, fetch_data, fa;
	logic [31:0] ea_addr, imm_value, base_wb_value;
	logic [63:0] fp_in, ext_mantissa;
	logic [95:0] ext_image;
	int          err_total, n_compared;
	ea_fp_unit dut (.clk_sys, .rst_n, .ea_start, .ea_mode, .pc_relative,
		.op_size, .address_register_base, .pc_value, .index_register_operand,
		.index_long, .index_scale, .short_byte_displacement,
		.short_word_displacement, .base_displacement, .bd_long,
		.outer_displacement, .od_present, .od_long, .ext_word,
		.data_register_operand, .fetch_req, .fetch_addr, .fetch_ack,
		.fetch_data, .ea_done, .ea_addr, .imm_value, .base_wb_en,
		.base_wb_value, .fp_load, .fp_fmt, .fp_in, .ext_image, .ext_sign,
		.ext_exponent, .ext_mantissa);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [95:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// answers one indirect fetch; fa stays unknown if none was asked for
	task automatic run_ea(input ea_mode_e md, input logic [31:0] fd);
		fa = 'x;
		@(posedge clk_sys) #1;
		ea_mode = md;
		ea_start = 1'b1;
		@(posedge clk_sys) #1;
		ea_start = 1'b0;
		for (int i = 0; i < 20 && ea_done !== 1'b1; i++) begin
			fetch_ack = fetch_req === 1'b1 && fetch_ack !== 1'b1;
			if (fetch_ack)
				fa = fetch_addr;
			fetch_data = fd;
			@(posedge clk_sys) #1;
		end
		fetch_ack = 1'b0;
		chk(ea_done, 1, "no done");
	endtask
	task automatic load_fp(input real_fmt_e f, input logic [63:0] v);
		@(posedge clk_sys) #1;
		fp_fmt = f;
		fp_in = v;
		fp_load = 1'b1;
		@(posedge clk_sys) #1;
		fp_load = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_incdec();
		logic [31:0] st;
		for (int k = 0; k < 3; k++) begin
			st = 32'h0000_0001 << k;
			op_size = op_size_e'(k);
			run_ea(M_POSTINC, 0);
			chk({base_wb_en, ea_addr}, {1'b1, 32'h0000_1000}, "postinc");
			chk(base_wb_value, 32'h0000_1000 + st, "postinc wb");
			run_ea(M_PREDEC, 0);
			chk(ea_addr, 32'h0000_1000 - st, "predec");
			chk(base_wb_en, 1, "predec en");
			chk(base_wb_value, 32'h0000_1000 - st, "predec wb");
		end
		run_ea(M_IND, 0);
		chk({base_wb_en, ea_addr}, {1'b0, 32'h0000_1000}, "plain");
		$display("test incdec done");
	endtask
	task automatic t_index();
		short_word_displacement = 16'h8000;
		run_ea(M_DISP16, 0);
		chk(ea_addr, 32'hffff_9000, "word disp");
		short_byte_displacement = 8'hfe;
		index_register_operand = 32'h0001_ffff;
		for (int s = 0; s < 4; s++) begin
			index_scale = s[1:0];
			run_ea(M_IDX8, 0);
			chk(ea_addr, 32'h0000_0ffe - (32'h0000_0001 << s), "scale");
		end
		index_long = 1'b1;
		index_scale = 2'h0;
		run_ea(M_IDX8, 0);
		chk(ea_addr, 32'h0002_0ffd, "long index");
		base_displacement = 32'h1234_8000;
		index_register_operand = 32'h0000_0003;
		index_scale = 2'h2;
		run_ea(M_IDXBD, 0);
		chk(ea_addr, 32'hffff_900c, "short bd");
		bd_long = 1'b1;
		run_ea(M_IDXBD, 0);
		chk(ea_addr, 32'h1234_900c, "long bd");
		$display("test index done");
	endtask
	task automatic t_mem();
		base_displacement = 32'h0000_0100;
		index_register_operand = 32'h0000_0004;
		index_scale = 2'h1;
		od_present = 1'b1;
		outer_displacement = 32'h0000_fff0;
		run_ea(M_MEMPRE, 32'h0000_2000);
		chk(fa, 32'h0000_1108, "pre fetch");
		chk(ea_addr, 32'h0000_1ff0, "pre od");
		run_ea(M_MEMPOST, 32'h0000_2000);
		chk(fa, 32'h0000_1100, "post fetch");
		chk(ea_addr, 32'h0000_1ff8, "post od");
		od_long = 1'b1;
		outer_displacement = 32'h0001_0000;
		run_ea(M_MEMPRE, 32'h0000_2000);
		chk(ea_addr, 32'h0001_2000, "long od");
		od_present = 1'b0;
		run_ea(M_MEMPRE, 32'h0000_2000);
		chk(ea_addr, 32'h0000_2000, "no od");
		$display("test mem done");
	endtask
	task automatic t_pc_abs();
		pc_relative = 1'b1;
		short_word_displacement = 16'h0010;
		run_ea(M_DISP16, 0);
		chk(ea_addr, 32'h0004_0010, "pc disp");
		run_ea(M_MEMPRE, 32'h0000_3000);
		chk(fa, 32'h0004_0108, "pc fetch");
		ext_word = 32'h0000_8004;
		run_ea(M_ABSW, 0);
		chk(ea_addr, 32'hffff_8004, "abs short");
		ext_word = 32'h8765_4321;
		run_ea(M_ABSL, 0);
		chk(ea_addr, 32'h8765_4321, "abs long");
		pc_relative = 1'b0;
		$display("test pc_abs done");
	endtask
	task automatic t_imm();
		logic [31:0] ex [3] = '{32'h0000_00ef, 32'h0000_beef, 32'hdead_beef};
		ext_word = 32'hdead_beef;
		for (int k = 0; k < 3; k++) begin
			op_size = op_size_e'(k);
			run_ea(M_IMM, 0);
			chk(imm_value, ex[k], "immediate");
		end
		$display("test imm done");
	endtask
	task automatic t_fp();
		load_fp(RF_DOUBLE, 64'h3ff0_0000_0000_0000);
		chk({ext_sign, ext_exponent}, {1'b0, 15'h3fff}, "double exp");
		chk(ext_mantissa[62:0], 0, "double frac");
		load_fp(RF_SINGLE, 64'h0000_0000_c000_0000);
		chk({ext_sign, ext_exponent}, {1'b1, 15'h4000}, "single exp");
		chk(ext_image[79:64], 0, "reserved");
		load_fp(RF_EXTENDED, 64'h0123_4567_89ab_cdef);
		chk(ext_image[95:64], {1'b1, 15'h4000, 16'h0000}, "image top");
		chk(ext_image[63:0], 64'h0123_4567_89ab_cdef, "image mant");
		$display("test fp done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// whole run is well under a thousand cycles
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial begin
		{rst_n, ea_start, pc_relative, index_long, bd_long} = '0;
		{od_present, od_long, fetch_ack, fp_load, index_scale} = '0;
		ea_mode = M_IND;
		op_size = SZ_BYTE;
		fp_fmt = RF_SINGLE;
		{short_byte_displacement, short_word_displacement} = '0;
		{base_displacement, outer_displacement, ext_word} = '0;
		{index_register_operand, fetch_data, fp_in} = '0;
		address_register_base = 32'h0000_1000;
		pc_value = 32'h0004_0000;
		data_register_operand = 32'h0000_0000;
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		t_incdec();
		t_index();
		t_mem();
		t_pc_abs();
		t_imm();
		t_fp();
		give_verdict();
	end
endmodule // tb_effective_address_and_fp_format
